//--- tsc_regs.svh
// Register offsets, field positions, reset values and timing figures
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH
`define TSC_GCFG_ADDR    8'h20
`define TSC_SEN_ADDR     8'h21
`define TSC_TTC_ADDR     8'h22
`define TSC_HOLD_ADDR    8'h23
`define TSC_GCFG2_ADDR   8'h44
`define TSC_GCFG_RST_B   8'ha0
`define TSC_GCFG_RST_C   8'h20
`define TSC_SEN_RST      8'h3f
`define TSC_TTC_RST      8'ha4
`define TSC_HOLD_RST     8'h07
`define TSC_GCFG2_RST    8'h40
`define TSC_GCFG_MASK    8'hb8
`define TSC_GCFG2_MASK   8'h6d
`define TSC_SEN_MASK     8'h3f
`define TSC_HOLD_MASK    8'h0f
`define TSC_TIMEOUT_BIT  7
`define TSC_DIG_OFF_BIT  5
`define TSC_LF_OFF_BIT   4
`define TSC_RECAL_EN_BIT 3
`define TSC_POL_BIT      6
`define TSC_KEEP_PWR_BIT 5
`define TSC_RF_ONLY_BIT  3
`define TSC_RF_OFF_BIT   2
`define TSC_NO_REL_BIT   0
`define TSC_CLK_KHZ      10000
`define TSC_SCL_LOW_MS   30
`define TSC_IDLE_US      200
`define TSC_STEP_MS      35
`define TSC_TICK_MS      1
`endif

//--- tsc_pkg.sv
// Shared types of the touch configuration and timing block
`default_nettype none
package tsc_pkg;
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tsc_req_t;

  typedef enum logic [1:0] {
    TS_IDLE  = 2'b00,
    TS_TOUCH = 2'b01,
    TS_HOLD  = 2'b10
  } tsc_tstate_t;
endpackage : tsc_pkg
`default_nettype wire

//--- tsc_cdc_hs.sv
// Toggle handshake carrying one word between two clock domains
`timescale 1ns/100ps
`default_nettype none
module tsc_cdc_hs #(
  parameter int unsigned W = 8
) (
  input  wire logic         src_clk,
  input  wire logic         dst_clk,
  input  wire logic         nrst,
  input  wire logic         src_valid,
  input  wire logic [W-1:0] src_data,
  output logic              src_busy,
  output logic              dst_valid,
  output logic [W-1:0]      dst_data
);
  logic         src_tog;
  logic         ack_s1;
  logic         ack_s2;
  logic         d_s1;
  logic         d_s2;
  logic         d_s3;
  logic [W-1:0] hold;

  // Source may not load a new word until the toggle has come back
  assign src_busy = src_tog ^ ack_s2;

  always_ff @(posedge src_clk or negedge nrst) begin
    if (!nrst) begin
      src_tog <= 1'b0;
      hold    <= '0;
      ack_s1  <= 1'b0;
      ack_s2  <= 1'b0;
    end else begin
      ack_s1 <= d_s2;
      ack_s2 <= ack_s1;
      if (src_valid && !src_busy) begin
        src_tog <= ~src_tog;
        hold    <= src_data;
      end
    end
  end

  always_ff @(posedge dst_clk or negedge nrst) begin
    if (!nrst) begin
      d_s1      <= 1'b0;
      d_s2      <= 1'b0;
      d_s3      <= 1'b0;
      dst_valid <= 1'b0;
      dst_data  <= '0;
    end else begin
      d_s1      <= src_tog;
      d_s2      <= d_s1;
      d_s3      <= d_s2;
      dst_valid <= d_s2 ^ d_s3;
      if (d_s2 ^ d_s3) begin
        dst_data <= hold;
      end
    end
  end
endmodule : tsc_cdc_hs
`default_nettype wire

//--- tsc_bus_watch.sv
// Serial bus clock-low timeout and idle reset detector
`timescale 1ns/100ps
`default_nettype none
module tsc_bus_watch #(
  parameter int unsigned LOW_CYC  = 300000,
  parameter int unsigned IDLE_CYC = 2000
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic enable,
  input  wire logic scl,
  input  wire logic sda,
  output logic      bus_abort,
  output logic      bus_idle_reset
);
  localparam int LW = $clog2(LOW_CYC + 2);
  localparam int IW = $clog2(IDLE_CYC + 2);
  logic [LW-1:0] low_cnt;
  logic [IW-1:0] idle_cnt;
  wire           low_on  = enable & ~scl;
  wire           idle_on = enable & scl & sda;
  wire           low_hit  = low_on & (low_cnt == LW'(LOW_CYC));
  wire           idle_hit = idle_on & (idle_cnt == IW'(IDLE_CYC));

  // Counters stop one past the limit so each episode fires once
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      low_cnt        <= '0;
      idle_cnt       <= '0;
      bus_abort      <= 1'b0;
      bus_idle_reset <= 1'b0;
    end else begin
      if (!low_on) low_cnt <= '0;
      else if (low_cnt <= LW'(LOW_CYC)) low_cnt <= low_cnt + LW'(1);
      if (!idle_on) idle_cnt <= '0;
      else if (idle_cnt <= IW'(IDLE_CYC)) idle_cnt <= idle_cnt + IW'(1);
      bus_abort      <= low_hit;
      bus_idle_reset <= idle_hit;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  tout_off_a: assert property (
    !enable |=> !bus_abort && !bus_idle_reset)
    else $error("timeout fired while disabled");
  idle_cause_a: assert property (
    $rose(bus_idle_reset) |-> $past(enable) && $past(scl) && $past(sda))
    else $error("idle reset without idle bus");
  abort_cause_a: assert property (
    $rose(bus_abort) |-> $past(enable) && !$past(scl))
    else $error("abort without clock held low");
endmodule : tsc_bus_watch
`default_nettype wire

//--- tsc_config_timing.sv
// Touch sensor global configuration and per-channel timing
`timescale 1ns/100ps
`default_nettype none
`include "tsc_regs.svh"
// Functional notes
// - Timeout on: abort if clock low >30ms
// - Timeout on: reset link if idle >200us
// - Timeout bit clear disables both checks
// - Timeout bit resets one rev B, zero C
// - Digital filter on: noise-band samples skip recal
// - Digital filter off: below-touch samples recal
// - Low-frequency noise zeroes delta unless disabled
// - Long-touch recal restarts after maximum duration
// - Maximum duration decoded by nonlinear table
// - Alert polarity: low open drain, else high
// - Keep front end powered between conversions
// - Radio-only status hides low-frequency noise
// - Radio noise zeroes delta unless disabled
// - Release interrupt suppressed when control set
// - Only enabled channels are sampled
// - Sampling cycle length independent of enables
// - Repeat spacing is (field+1) times 35ms
// - Hold reported after (field+1) times 35ms
// - Noise status follows analog flags, unlatched
module tsc_config_timing #(
  parameter bit          REV_C       = 1'b1,
  parameter int unsigned SCL_LOW_CYC = `TSC_SCL_LOW_MS * `TSC_CLK_KHZ,
  parameter int unsigned TICK_CYC    = `TSC_TICK_MS * `TSC_CLK_KHZ
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              link_clk,
  input  wire logic              link_req_valid,
  input  wire tsc_pkg::tsc_req_t link_req,
  output logic                   link_busy,
  output logic                   link_rsp_valid,
  output logic [7:0]             link_rdata,
  input  wire logic              scl_pin,
  input  wire logic              sda_pin,
  output logic                   bus_abort,
  output logic                   bus_idle_reset,
  input  wire logic              sample_valid,
  input  wire logic [5:0][7:0]   raw_delta,
  input  wire logic [5:0]        lf_noise,
  input  wire logic [5:0]        rf_noise,
  input  wire logic [7:0]        touch_thr,
  input  wire logic [7:0]        noise_thr,
  input  wire logic [5:0]        repeat_en,
  input  wire logic              alert_req,
  input  wire logic              idle_window,
  output logic [5:0][7:0]        filt_delta,
  output logic [5:0]             recal_use,
  output logic [5:0]             noise_status,
  output logic [5:0]             long_touch_recal,
  output logic [5:0]             sample_mask,
  output logic [5:0]             touch_irq,
  output logic [5:0]             hold_event,
  output logic                   frontend_power,
  output logic                   alert_out,
  output logic                   alert_oe
);
  localparam int CH       = 6;
  localparam int IDLE_CYC = `TSC_IDLE_US * `TSC_CLK_KHZ / 1000;
  localparam int TW       = $clog2(TICK_CYC);

  //////////////////////////////////////////////////////////////////////
  function automatic logic [9:0] step_ms(input logic [3:0] v);
    step_ms = 10'(({6'h00, v} + 10'h001) * `TSC_STEP_MS);
  endfunction : step_ms

  function automatic logic [13:0] long_ms(input logic [3:0] c);
    case (c)
      4'h0: long_ms = 14'h0230;
      4'h1: long_ms = 14'h0348;
      4'h2: long_ms = 14'h0460;
      4'h3: long_ms = 14'h0578;
      4'h4: long_ms = 14'h0690;
      4'h5: long_ms = 14'h08c0;
      4'h6: long_ms = 14'h0af0;
      4'h7: long_ms = 14'h0d20;
      4'h8: long_ms = 14'h0f50;
      4'h9: long_ms = 14'h1180;
      4'ha: long_ms = 14'h15e0;
      4'hb: long_ms = 14'h1a40;
      4'hc: long_ms = 14'h1ea0;
      4'hd: long_ms = 14'h22ca;
      4'he: long_ms = 14'h2760;
      default: long_ms = 14'h2bc0;
    endcase
  endfunction : long_ms

  //////////////////////////////////////////////////////////////////////
  tsc_pkg::tsc_req_t   rq;
  logic                rq_valid;
  logic                rq_busy;
  logic                pend;
  logic                rsp_valid;
  logic [7:0]          rsp_data;
  logic [7:0]          gcfg;
  logic [7:0]          sen;
  logic [7:0]          ttc;
  logic [7:0]          hold_cfg;
  logic [7:0]          gcfg2;
  logic [1:0]          scl_sy;
  logic [1:0]          sda_sy;
  logic [TW-1:0]       tick_cnt;
  logic                ms_tick;
  logic [CH-1:0]       tdet;
  tsc_pkg::tsc_tstate_t st [CH];
  tsc_pkg::tsc_tstate_t next_st [CH];
  logic [13:0]         cnt [CH];
  logic [13:0]         next_cnt [CH];
  logic [9:0]          rcnt [CH];
  logic [9:0]          next_rcnt [CH];
  logic [CH-1:0]       next_irq;
  logic [CH-1:0]       next_hev;
  logic [CH-1:0]       next_lrc;
  logic [CH-1:0][7:0]  next_filt;
  logic [CH-1:0]       next_recal;
  logic [CH-1:0]       next_stat;
  logic [CH-1:0]       next_tdet;

  //////////////////////////////////////////////////////////////////////
  // Link side: one request in flight until its answer returns
  tsc_cdc_hs #(.W($bits(tsc_pkg::tsc_req_t))) u_req (
    .src_clk   (link_clk),
    .dst_clk   (clock),
    .nrst      (nrst),
    .src_valid (link_req_valid & ~pend),
    .src_data  (link_req),
    .src_busy  (rq_busy),
    .dst_valid (rq_valid),
    .dst_data  (rq)
  );

  tsc_cdc_hs #(.W(8)) u_rsp (
    .src_clk   (clock),
    .dst_clk   (link_clk),
    .nrst      (nrst),
    .src_valid (rsp_valid),
    .src_data  (rsp_data),
    .src_busy  (),
    .dst_valid (link_rsp_valid),
    .dst_data  (link_rdata)
  );

  assign link_busy = rq_busy | pend;

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) pend <= 1'b0;
    else if (link_req_valid && !link_busy) pend <= 1'b1;
    else if (link_rsp_valid) pend <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  wire       wr_en    = rq_valid & rq.we;
  wire       wr_gcfg  = wr_en & (rq.addr == `TSC_GCFG_ADDR);
  wire       wr_sen   = wr_en & (rq.addr == `TSC_SEN_ADDR);
  wire       wr_ttc   = wr_en & (rq.addr == `TSC_TTC_ADDR);
  wire       wr_hold  = wr_en & (rq.addr == `TSC_HOLD_ADDR);
  wire       wr_gcfg2 = wr_en & (rq.addr == `TSC_GCFG2_ADDR);
  wire [7:0] rd_data  =
    (rq.addr == `TSC_GCFG_ADDR)  ? gcfg :
    (rq.addr == `TSC_SEN_ADDR)   ? sen :
    (rq.addr == `TSC_TTC_ADDR)   ? ttc :
    (rq.addr == `TSC_HOLD_ADDR)  ? hold_cfg :
    (rq.addr == `TSC_GCFG2_ADDR) ? gcfg2 : 8'h00;

  wire tout_en   = gcfg[`TSC_TIMEOUT_BIT];
  wire dig_off   = gcfg[`TSC_DIG_OFF_BIT];
  wire lf_off    = gcfg[`TSC_LF_OFF_BIT];
  wire recal_en  = gcfg[`TSC_RECAL_EN_BIT];
  wire alert_pol = gcfg2[`TSC_POL_BIT];
  wire keep_pwr  = gcfg2[`TSC_KEEP_PWR_BIT];
  wire rf_only   = gcfg2[`TSC_RF_ONLY_BIT];
  wire rf_off    = gcfg2[`TSC_RF_OFF_BIT];
  wire no_rel    = gcfg2[`TSC_NO_REL_BIT];
  wire [13:0] max_ms  = long_ms(ttc[7:4]);
  wire [9:0]  rpt_ms  = step_ms(ttc[3:0]);
  wire [9:0]  hold_ms = step_ms(hold_cfg[3:0]);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gcfg      <= REV_C ? `TSC_GCFG_RST_C : `TSC_GCFG_RST_B;
      sen       <= `TSC_SEN_RST;
      ttc       <= `TSC_TTC_RST;
      hold_cfg  <= `TSC_HOLD_RST;
      gcfg2     <= `TSC_GCFG2_RST;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
    end else begin
      if (wr_gcfg) gcfg <= rq.wdata & `TSC_GCFG_MASK;
      if (wr_sen) sen <= rq.wdata & `TSC_SEN_MASK;
      if (wr_ttc) ttc <= rq.wdata;
      if (wr_hold) hold_cfg <= rq.wdata & `TSC_HOLD_MASK;
      if (wr_gcfg2) gcfg2 <= rq.wdata & `TSC_GCFG2_MASK;
      rsp_valid <= rq_valid;
      rsp_data  <= rd_data;
    end
  end

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
    end else begin
      scl_sy <= {scl_sy[0], scl_pin};
      sda_sy <= {sda_sy[0], sda_pin};
    end
  end

  tsc_bus_watch #(.LOW_CYC(SCL_LOW_CYC), .IDLE_CYC(IDLE_CYC)) u_watch (
    .clock          (clock),
    .nrst           (nrst),
    .enable         (tout_en),
    .scl            (scl_sy[1]),
    .sda            (sda_sy[1]),
    .bus_abort      (bus_abort),
    .bus_idle_reset (bus_idle_reset)
  );

  //////////////////////////////////////////////////////////////////////
  // Disabled channels are masked only; the cycle timer is elsewhere
  assign sample_mask = sen[CH-1:0];

  for (genvar g = 0; g < CH; g++) begin : g_ch
    wire blk    = (lf_noise[g] & ~lf_off) | (rf_noise[g] & ~rf_off);
    wire over_t = $signed(next_filt[g]) >= $signed(touch_thr);
    wire over_n = $signed(next_filt[g]) > $signed(noise_thr);
    assign next_filt[g]  = (blk | ~sen[g]) ? 8'h00 : raw_delta[g];
    assign next_stat[g]  = rf_noise[g] | (lf_noise[g] & ~rf_only);
    assign next_recal[g] = sen[g] & ~over_t & (dig_off | ~over_n);
    assign next_tdet[g]  = sen[g] & over_t & ~next_filt[g][7];
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      filt_delta   <= '0;
      recal_use    <= '0;
      noise_status <= '0;
      tdet         <= '0;
    end else if (sample_valid) begin
      filt_delta   <= next_filt;
      recal_use    <= next_recal;
      noise_status <= next_stat;
      tdet         <= next_tdet;
    end
  end

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= '0;
      ms_tick  <= 1'b0;
    end else begin
      ms_tick  <= (tick_cnt == TW'(TICK_CYC - 1));
      tick_cnt <= (tick_cnt == TW'(TICK_CYC - 1)) ? '0 : tick_cnt + TW'(1);
    end
  end

  always_comb begin
    for (int i = 0; i < CH; i++) begin
      next_st[i]   = st[i];
      next_cnt[i]  = cnt[i];
      next_rcnt[i] = rcnt[i];
      next_irq[i]  = 1'b0;
      next_hev[i]  = 1'b0;
      next_lrc[i]  = 1'b0;
      case (st[i])
        tsc_pkg::TS_IDLE: begin
          if (tdet[i]) begin
            next_st[i]  = tsc_pkg::TS_TOUCH;
            next_cnt[i] = '0;
            next_irq[i] = 1'b1;
          end
        end
        tsc_pkg::TS_TOUCH, tsc_pkg::TS_HOLD: begin
          if (!tdet[i]) begin
            next_st[i]  = tsc_pkg::TS_IDLE;
            next_irq[i] = ~no_rel;
          end else if (ms_tick) begin
            if (cnt[i] != 14'h3fff) next_cnt[i] = cnt[i] + 14'h0001;
            if (rcnt[i] != 10'h3ff) next_rcnt[i] = rcnt[i] + 10'h001;
            if (recal_en && cnt[i] >= max_ms) begin
              next_lrc[i] = 1'b1;
              next_cnt[i] = '0;
            end
            if (st[i] == tsc_pkg::TS_TOUCH && repeat_en[i] &&
                cnt[i] >= {4'h0, hold_ms}) begin
              next_st[i]   = tsc_pkg::TS_HOLD;
              next_hev[i]  = 1'b1;
              next_rcnt[i] = '0;
            end
            if (st[i] == tsc_pkg::TS_HOLD &&
                rcnt[i] >= rpt_ms - 10'h001) begin
              next_irq[i]  = 1'b1;
              next_rcnt[i] = '0;
            end
          end
        end
        default: next_st[i] = tsc_pkg::TS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < CH; i++) begin
        st[i]   <= tsc_pkg::TS_IDLE;
        cnt[i]  <= '0;
        rcnt[i] <= '0;
      end
      touch_irq        <= '0;
      hold_event       <= '0;
      long_touch_recal <= '0;
    end else begin
      st               <= next_st;
      cnt              <= next_cnt;
      rcnt             <= next_rcnt;
      touch_irq        <= next_irq;
      hold_event       <= next_hev;
      long_touch_recal <= next_lrc;
    end
  end

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      frontend_power <= 1'b1;
      alert_out      <= 1'b0;
      alert_oe       <= 1'b0;
    end else begin
      frontend_power <= ~idle_window | keep_pwr;
      alert_out      <= alert_pol ? 1'b0 : alert_req;
      alert_oe       <= alert_pol ? alert_req : 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence rel_s;
    st[0] != tsc_pkg::TS_IDLE && !tdet[0];
  endsequence
  sequence press_s;
    st[0] == tsc_pkg::TS_IDLE ##1 st[0] == tsc_pkg::TS_TOUCH;
  endsequence

  lf_block_a: assert property (
    sample_valid && sen[0] && lf_noise[0] && !lf_off
    |=> filt_delta[0] == 8'h00)
    else $error("low-frequency noise not blocked");
  rf_pass_a: assert property (
    sample_valid && sen[0] && rf_noise[0] && !lf_noise[0] && rf_off
    |=> filt_delta[0] == $past(raw_delta[0]))
    else $error("radio noise blocked while filter off");
  stat_rf_only_a: assert property (
    sample_valid && lf_noise[0] && !rf_noise[0] && rf_only
    |=> !noise_status[0])
    else $error("low-frequency noise shown in radio-only mode");
  stat_clear_a: assert property (
    sample_valid && !lf_noise[0] && !rf_noise[0] |=> !noise_status[0])
    else $error("noise status held without noise");
  dig_band_a: assert property (
    sample_valid && sen[0] && !dig_off && next_filt[0][7] == 1'b0 &&
    $signed(next_filt[0]) > $signed(noise_thr) &&
    $signed(next_filt[0]) < $signed(touch_thr) |=> !recal_use[0])
    else $error("noise-band sample used for recal");
  chan_off_a: assert property (
    sample_valid && !sen[0] |=> filt_delta[0] == 8'h00 && !recal_use[0])
    else $error("disabled channel sampled");
  rel_quiet_a: assert property (
    rel_s and no_rel |=> !touch_irq[0])
    else $error("release interrupt while suppressed");
  press_irq_a: assert property (
    press_s |-> touch_irq[0])
    else $error("press without interrupt");
  alert_pol_a: assert property (
    alert_pol && alert_req ##1 alert_pol && alert_req
    |-> !alert_out && alert_oe)
    else $error("alert not driven low open drain");
endmodule : tsc_config_timing
`default_nettype wire

//--- tsc_host.sv
// Link-side host model issuing one register request at a time
`timescale 1ns/100ps
`default_nettype none
module tsc_host (
  input  wire logic             link_clk,
  input  wire logic             link_busy,
  input  wire logic             link_rsp_valid,
  input  wire logic [7:0]       link_rdata,
  output var  logic             link_req_valid,
  output var  tsc_pkg::tsc_req_t link_req
);
  initial begin
    link_req_valid = 1'b0;
    link_req = '0;
  end
  // Request held until the answer edge; ok stays clear if none comes
  task automatic xfer(input logic we, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge link_clk);
    #1;
    link_req_valid = 1'b1;
    link_req = '{we, a, d};
    for (n = 0; n < 100 && !ok; n++) begin
      @(posedge link_clk);
      ok = (link_rsp_valid === 1'b1);
    end
    q = link_rdata;
    #1;
    link_req_valid = 1'b0;
    // Released lines show no stale value
    link_req = ~link_req;
  endtask : xfer
endmodule : tsc_host
`default_nettype wire

//--- tb_top.sv
// Self-checking bench of the touch configuration and timing block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int unsigned LOWC = 50;
  localparam int unsigned TICK = 4;
  localparam logic [7:0] RA [5] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h44};
  localparam logic [7:0] RV [5] = '{8'h20, 8'h3f, 8'ha4, 8'h07, 8'h40};
  localparam logic [7:0] RM [5] = '{8'hb8, 8'h3f, 8'hff, 8'h0f, 8'h6d};
  logic              clock, nrst, link_clk, link_req_valid;
  logic              link_busy, link_rsp_valid, scl_pin, sda_pin;
  tsc_pkg::tsc_req_t link_req;
  logic [7:0]        link_rdata, touch_thr, noise_thr, q, g, h, d8;
  logic [5:0][7:0]   raw_delta, filt_delta, dv;
  logic [5:0]        lf_noise, rf_noise, repeat_en, recal_use;
  logic [5:0]        noise_status, long_touch_recal, sample_mask;
  logic [5:0]        touch_irq, hold_event, en, lf, rf;
  logic              bus_abort, bus_idle_reset, sample_valid, alert_req;
  logic              idle_window, frontend_power, alert_out, alert_oe, z;
  int                errors = 0, comparisons = 0, cyc = 0, k, c;
  int                n_ab = 0, n_id = 0, n_irq = 0, n_hold = 0, n_rc = 0;
  int                t_irq, t_hold, t_rc;
  integer            seed;

  tsc_config_timing #(.SCL_LOW_CYC(LOWC), .TICK_CYC(TICK)) dut (.*);
  tsc_host host (.*);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  always @(posedge clock) begin
    cyc++;
    n_ab += int'(bus_abort === 1'b1);
    n_id += int'(bus_idle_reset === 1'b1);
    if (touch_irq[0] === 1'b1) begin
      if (n_irq == 0) t_irq = cyc;
      n_irq++;
    end
    if (hold_event[0] === 1'b1) begin
      n_hold++;
      t_hold = cyc;
    end
    if (long_touch_recal[0] === 1'b1) begin
      n_rc++;
      t_rc = cyc;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic wcyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wcyc
  task automatic rw(input logic we, input logic [7:0] a, input logic [7:0] d);
    bit ok;
    host.xfer(we, a, d, q, ok);
    if (!ok) begin
      errors++;
      test_done();
    end
    wcyc(3);
  endtask : rw
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rw(1'b0, a, 8'h00);
    check(q, e);
  endtask : rd
  task automatic samp(input logic [5:0][7:0] d, input logic [5:0] l,
    input logic [5:0] r);
    raw_delta = d;
    lf_noise = l;
    rf_noise = r;
    sample_valid = 1'b1;
    wcyc(1);
    sample_valid = 1'b0;
    wcyc(2);
  endtask : samp
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h5001;
    {scl_pin, sda_pin, sample_valid, alert_req, idle_window} = 5'b10000;
    {raw_delta, lf_noise, rf_noise} = '0;
    touch_thr = 8'h28;
    noise_thr = 8'h14;
    repeat_en = 6'h01;
    nrst = 1'b0;
    wcyc(20);
    nrst = 1'b1;
    wcyc(4);
    for (k = 0; k < 5; k++) rd(RA[k], RV[k]);
    rd(8'h30, 8'h00);
    for (c = 0; c < 15; c++) begin
      k = c % 5;
      d8 = 8'($random(seed));
      rw(1'b1, RA[k], d8);
      rd(RA[k], d8 & RM[k]);
      if (k == 1) check({2'b00, sample_mask}, d8 & 8'h3f);
    end
    for (k = 0; k < 24; k++) begin
      g = 8'($random(seed)) & 8'h30;
      h = 8'($random(seed)) & 8'h0c;
      en = 6'($random(seed));
      lf = k[0] ? 6'($random(seed)) : 6'h00;
      rf = k[1] ? 6'($random(seed)) : 6'h00;
      dv = 48'($random(seed)) ^ (48'($random(seed)) << 16);
      // Corner: channel 0 inside the noise band with the filter on
      if (k < 2) begin
        dv[0] = 8'h1e;
        g[5] = 1'b0;
        en[0] = 1'b1;
      end
      rw(1'b1, 8'h20, g);
      rw(1'b1, 8'h44, h);
      rw(1'b1, 8'h21, {2'b00, en});
      samp(dv, lf, rf);
      for (c = 0; c < 6; c++) begin
        z = !en[c] || (lf[c] && !g[4]) || (rf[c] && !h[2]);
        check(filt_delta[c], z ? 8'h00 : dv[c]);
        if (!lf[c] && !rf[c] && en[c])
          check(8'(recal_use[c]), 8'($signed(dv[c]) < $signed(touch_thr) &&
            (g[5] || !($signed(dv[c]) > $signed(noise_thr)))));
      end
      check({2'b00, noise_status & en}, {2'b00, (h[3] ? rf : lf | rf) & en});
    end
    for (k = 0; k < 8; k++) begin
      rw(1'b1, 8'h44, {1'b0, k[0], k[1], 5'b00000});
      alert_req = k[2];
      idle_window = k[2];
      wcyc(3);
      check({6'b0, alert_oe, alert_out}, k[0] ? {6'b0, k[2], 1'b0} : {6'b0, 1'b1, k[2]});
      check(8'(frontend_power), 8'(k[1] | !k[2]));
    end
    for (k = 0; k < 2; k++) begin
      rw(1'b1, 8'h20, k[0] ? 8'h80 : 8'h00);
      n_ab = 0;
      n_id = 0;
      scl_pin = 1'b0;
      wcyc(LOWC - 5);
      check(8'(n_ab), 8'h00);
      wcyc(15);
      check(8'(n_ab), 8'(k));
      scl_pin = 1'b1;
      sda_pin = 1'b1;
      wcyc(1990);
      check(8'(n_id), 8'h00);
      wcyc(30);
      check(8'(n_id != 0), 8'(k));
      sda_pin = 1'b0;
    end
    rw(1'b1, 8'h20, 8'h28);
    rw(1'b1, 8'h21, 8'h3f);
    rw(1'b1, 8'h22, 8'h00);
    rw(1'b1, 8'h23, 8'h01);
    rw(1'b1, 8'h44, 8'h00);
    samp('0, '0, '0);
    wcyc(20);
    for (k = 0; k < 2; k++) begin
      n_irq = 0;
      n_hold = 0;
      n_rc = 0;
      samp(48'h64, '0, '0);
      wcyc(k ? 200 : 2300);
      samp('0, '0, '0);
      wcyc(20);
      check(8'(n_hold), 8'(1 - k));
      check(8'(n_irq), k ? 8'd1 : 8'd16);
      if (k == 0) begin
        check(8'((t_hold - t_irq) inside {[272:288]}), 8'h01);
        check(8'(n_rc), 8'h01);
        check(8'((t_rc - t_irq) inside {[2226:2250]}), 8'h01);
        rw(1'b1, 8'h44, 8'h01);
      end
    end
    test_done();
  end
endmodule : tb_top
`default_nettype wire
